/* File: include/rcs_pkg.sv */
// Shared constants and types for the data-subcarrier coder settings block
package rcs_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int BLK_W = 26;

	localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_MASK_CNT = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_MASK_A = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_MASK_B = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_MASK_C = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_MASK_D = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_PI = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_GENRE = 8'h1C;
	localparam logic [ADDR_W-1:0] OFS_PHASE = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_RT_CFG = 8'h24;
	localparam logic [ADDR_W-1:0] OFS_CHAR = 8'h28;
	localparam logic [ADDR_W-1:0] OFS_ROTATE = 8'h2C;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h30;
	localparam logic [ADDR_W-1:0] OFS_PRESET = 8'h34;

	// CTRL fields
	localparam int CTRL_INJECT = 0;
	localparam int CTRL_MUSIC = 1;
	localparam int CTRL_BVER = 2;
	localparam int CTRL_G10A = 3;
	localparam int CTRL_SRC_LO = 4;
	localparam int CTRL_CH_LO = 8;
	// RT_CFG fields
	localparam int RT_LEN_LO = 8;
	localparam int RT_NEW = 15;
	// CHAR fields
	localparam int CHAR_ADDR_LO = 16;
	// ROTATE fields
	localparam int ROT_CNT_LO = 8;

	localparam logic [1:0] SRC_TONE = 2'h3;
	localparam logic [2:0] CH_MIN = 3'h1;
	localparam logic [2:0] CH_MAX = 3'h5;
	localparam logic [2:0] CH_INDEP = 3'h5;
	localparam logic [8:0] PHASE_MAX = 9'h167;
	localparam logic [5:0] ROT_SEC_MAX = 6'h3B;
	localparam logic [4:0] ROT_NAMES = 5'h14;
	localparam logic [6:0] RT_LEN_A = 7'h40;
	localparam logic [6:0] RT_LEN_B = 7'h20;

	// Character store layout
	localparam int CHR_DEPTH = 304;
	localparam logic [8:0] CHR_NAME = 9'h000;
	localparam logic [8:0] CHR_LABEL = 9'h008;
	localparam logic [8:0] CHR_ROT = 9'h010;
	localparam logic [8:0] CHR_TEXT = 9'h0B0;
	localparam logic [7:0] CHR_SPACE = 8'h20;

	// Reset values
	localparam logic [2:0] CH_RST = 3'h3;
	localparam logic [15:0] PI_RST = 16'h0000;

	// One second at the 25 MHz clock
	localparam int CLK_HZ = 25_000_000;
	localparam int SEC_TIME_MS = 1000;
	localparam int SEC_CYCLES = (CLK_HZ / 1000) * SEC_TIME_MS;

	typedef struct packed {
		logic [3:0][BLK_W-1:0] blk;
	} rcs_group_type;

	typedef struct packed {
		logic        is_charset;
		logic [1:0]  index;
		logic [15:0] data;
	} rcs_segment_type;

	typedef struct packed {
		logic [15:0] program_identifier;
		logic [4:0]  genre_code;
		logic        genre_label_on;
		logic        music_speech_flag;
		logic [8:0]  subcarrier_phase;
		logic [2:0]  channel_arrangement;
		logic [1:0]  input_source;
		logic        text_ab;
		logic [6:0]  text_len;
		logic        text_active;
	} rcs_settings_type;
endpackage

/* File: core/rcs_tick_div.sv */
// Divider giving a one-cycle pulse per second
`timescale 1ns/1ns
`default_nettype none
module rcs_tick_div #(
	parameter int DIV = 25_000_000
) (
	input  wire logic sys_clk_i,
	input  wire logic resetn_i,
	input  wire logic clear_i,
	output logic      tick_o
);
	logic [31:0] cnt_q;

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt_q <= 32'h0;
			tick_o <= 1'b0;
		end else if (clear_i) begin
			cnt_q <= 32'h0;
			tick_o <= 1'b0;
		end else if (cnt_q == 32'(DIV - 1)) begin
			cnt_q <= 32'h0;
			tick_o <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 32'h1;
			tick_o <= 1'b0;
		end
	end
endmodule // rcs_tick_div
`default_nettype wire

/* File: core/rcs_mask_engine.sv */
// Bit-error injection on the outgoing group stream
`timescale 1ns/1ns
`default_nettype none
module rcs_mask_engine (
	input  wire logic                   sys_clk_i,
	input  wire logic                   resetn_i,
	input  wire logic                   start_i,
	input  wire logic                   stop_i,
	input  wire logic [7:0]             cnt_cfg_i,
	input  wire logic [7:0]             gap_cfg_i,
	input  wire rcs_pkg::rcs_group_type mask_i,
	input  wire logic                   grp_valid_i,
	input  wire rcs_pkg::rcs_group_type grp_i,
	output logic                        grp_valid_o,
	output rcs_pkg::rcs_group_type      grp_o,
	output logic                        active_o,
	output logic [7:0]                  left_o
);
	import rcs_pkg::*;

	logic       counted_q;
	logic [7:0] gap_cfg_q;
	logic [7:0] gap_left_q;
	logic       errored;
	logic       done;

	assign errored = active_o && grp_valid_i && (gap_left_q == 8'h0);
	assign done = errored && counted_q && (left_o == 8'h1);

	// Start wins over a same-cycle finish; rcs_coder gates start_i off while active, so a replay written during a run is lost
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i)
			active_o <= 1'b0;
		else if (start_i)
			active_o <= 1'b1;
		else if (stop_i || done)
			active_o <= 1'b0;
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			counted_q <= 1'b0;
			gap_cfg_q <= 8'h0;
			left_o <= 8'h0;
			gap_left_q <= 8'h0;
		end else if (start_i) begin
			counted_q <= (cnt_cfg_i != 8'h0);
			gap_cfg_q <= gap_cfg_i;
			left_o <= cnt_cfg_i;
			gap_left_q <= 8'h0;
		end else if (active_o && grp_valid_i) begin
			if (gap_left_q != 8'h0) begin
				gap_left_q <= gap_left_q - 8'h1;
			end else begin
				gap_left_q <= gap_cfg_q;
				if (counted_q)
					left_o <= left_o - 8'h1;
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			grp_valid_o <= 1'b0;
			grp_o <= '0;
		end else begin
			grp_valid_o <= grp_valid_i;
			if (grp_valid_i)
				grp_o <= errored ? (grp_i ^ mask_i) : grp_i;
		end
	end
endmodule // rcs_mask_engine
`default_nettype wire

/* File: core/rcs_coder.sv */
// Command-driven settings store, name segmenter and error injection top
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module rcs_coder #(
	parameter int SEC_CYCLES = rcs_pkg::SEC_CYCLES
) (
	input  wire logic                     sys_clk_i,
	input  wire logic                     resetn_i,
	input  wire logic [rcs_pkg::ADDR_W-1:0] addr_i,
	input  wire logic [rcs_pkg::DATA_W-1:0] wdata_i,
	input  wire logic                     wr_i,
	input  wire logic                     rd_i,
	output logic [rcs_pkg::DATA_W-1:0]    rdata_o,
	input  wire logic                     grp_valid_i,
	input  wire rcs_pkg::rcs_group_type   grp_i,
	output logic                          grp_valid_o,
	output rcs_pkg::rcs_group_type        grp_o,
	input  wire logic                     seg_req_i,
	output logic                          seg_valid_o,
	output rcs_pkg::rcs_segment_type      seg_o,
	input  wire logic                     text_sent_i,
	output rcs_pkg::rcs_settings_type     settings_o
);
	import rcs_pkg::*;

	// Software-visible settings
	logic [7:0]        cnt_cfg_q;
	logic [7:0]        gap_cfg_q;
	rcs_group_type     mask_q;
	logic [15:0]       pi_q;
	logic [4:0]        genre_q;
	logic [1:0]        charset_q;
	logic [8:0]        phase_q;
	logic [2:0]        chan_q;
	logic [1:0]        src_q;
	logic              music_q;
	logic              bver_q;
	logic              g10a_q;
	logic [3:0]        rt_rep_q;
	logic [6:0]        rt_len_q;
	logic              ab_q;
	logic [3:0]        rt_left_q;
	logic [8:0]        chr_addr_q;
	logic [5:0]        rot_sec_q;
	logic [4:0]        rot_cnt_q;
	logic              reject_q;

	// Rotation and segment state
	logic [4:0]        rot_idx_q;
	logic [5:0]        rot_elapsed_q;
	logic [1:0]        seg_idx_q;
	logic              cs_sent_q;

	logic [7:0]        chr_mem [0:CHR_DEPTH-1];

	logic              wr_ctrl;
	logic              wr_preset;
	logic              inject_on;
	logic [7:0]        inject_left;
	logic              sec_tick;
	logic              rot_on;
	logic [8:0]        name_base;
	logic [8:0]        pair_addr;
	logic [2:0]        new_chan;
	logic [1:0]        new_src;
	logic              chan_ok;
	logic [8:0]        new_phase;
	logic [6:0]        new_len;
	logic [6:0]        len_limit;

	function automatic logic hit(input logic [ADDR_W-1:0] ofs);
		hit = wr_i && (addr_i == ofs);
	endfunction

	assign wr_ctrl = hit(OFS_CTRL);
	assign wr_preset = hit(OFS_PRESET) && wdata_i[0];

	assign new_chan = wdata_i[CTRL_CH_LO +: 3];
	assign new_src = wdata_i[CTRL_SRC_LO +: 2];
	assign chan_ok = (new_chan >= CH_MIN) && (new_chan <= CH_MAX) &&
		!((new_chan == CH_INDEP) && (new_src == SRC_TONE));
	assign new_phase = wdata_i[8:0];
	assign len_limit = bver_q ? RT_LEN_B : RT_LEN_A;
	assign new_len = wdata_i[RT_LEN_LO +: 7];

	rcs_mask_engine u_mask (
		.sys_clk_i   (sys_clk_i),
		.resetn_i    (resetn_i),
		.start_i     (wr_ctrl && wdata_i[CTRL_INJECT] && !inject_on),
		.stop_i      ((wr_ctrl && !wdata_i[CTRL_INJECT]) || wr_preset),
		.cnt_cfg_i   (cnt_cfg_q),
		.gap_cfg_i   (gap_cfg_q),
		.mask_i      (mask_q),
		.grp_valid_i (grp_valid_i),
		.grp_i       (grp_i),
		.grp_valid_o (grp_valid_o),
		.grp_o       (grp_o),
		.active_o    (inject_on),
		.left_o      (inject_left)
	);

	rcs_tick_div #(
		.DIV (SEC_CYCLES)
	) u_sec (
		.sys_clk_i (sys_clk_i),
		.resetn_i  (resetn_i),
		.clear_i   (!rot_on),
		.tick_o    (sec_tick)
	);

	// Error mask settings; counts and masks are plain 8/26-bit stores
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt_cfg_q <= 8'h0;
			gap_cfg_q <= 8'h0;
			mask_q <= '0;
		end else if (wr_preset) begin
			cnt_cfg_q <= 8'h0;
			gap_cfg_q <= 8'h0;
			mask_q <= '0;
		end else if (hit(OFS_MASK_CNT)) begin
			cnt_cfg_q <= wdata_i[7:0];
			gap_cfg_q <= wdata_i[15:8];
		end else if (hit(OFS_MASK_A)) begin
			mask_q.blk[0] <= wdata_i[BLK_W-1:0];
		end else if (hit(OFS_MASK_B)) begin
			mask_q.blk[1] <= wdata_i[BLK_W-1:0];
		end else if (hit(OFS_MASK_C)) begin
			mask_q.blk[2] <= wdata_i[BLK_W-1:0];
		end else if (hit(OFS_MASK_D)) begin
			mask_q.blk[3] <= wdata_i[BLK_W-1:0];
		end
	end

	// Control word; a refused channel code keeps the previous one
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			chan_q <= CH_RST;
			src_q <= 2'h0;
			music_q <= 1'b0;
			bver_q <= 1'b0;
			g10a_q <= 1'b0;
		end else if (wr_preset) begin
			music_q <= 1'b0;
			bver_q <= 1'b0;
			g10a_q <= 1'b0;
		end else if (wr_ctrl) begin
			src_q <= new_src;
			music_q <= wdata_i[CTRL_MUSIC];
			bver_q <= wdata_i[CTRL_BVER];
			g10a_q <= wdata_i[CTRL_G10A];
			if (chan_ok)
				chan_q <= new_chan;
		end
	end

	// Last refused write stays visible until the next accepted check
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i)
			reject_q <= 1'b0;
		else if (wr_ctrl)
			reject_q <= !chan_ok;
		else if (hit(OFS_PHASE))
			reject_q <= (new_phase > PHASE_MAX);
		else if (hit(OFS_ROTATE))
			reject_q <= (wdata_i[5:0] > ROT_SEC_MAX) ||
				(wdata_i[ROT_CNT_LO +: 5] > ROT_NAMES);
	end

	// Identity, genre, charset and phase
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pi_q <= PI_RST;
			genre_q <= 5'h0;
			charset_q <= 2'h0;
			phase_q <= 9'h0;
		end else if (wr_preset) begin
			pi_q <= PI_RST;
			genre_q <= 5'h0;
			charset_q <= 2'h0;
			phase_q <= 9'h0;
		end else begin
			if (hit(OFS_PI))
				pi_q <= wdata_i[15:0];
			if (hit(OFS_GENRE)) begin
				genre_q <= wdata_i[4:0];
				charset_q <= wdata_i[9:8];
			end
			if (hit(OFS_PHASE) && (new_phase <= PHASE_MAX))
				phase_q <= new_phase;
		end
	end

	// Radio text: length clamp, repeat count and A/B toggle
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rt_rep_q <= 4'h0;
			rt_len_q <= 7'h0;
			ab_q <= 1'b0;
			rt_left_q <= 4'h0;
		end else if (wr_preset) begin
			rt_rep_q <= 4'h0;
			rt_len_q <= 7'h0;
			ab_q <= 1'b0;
			rt_left_q <= 4'h0;
		end else if (hit(OFS_RT_CFG)) begin
			rt_rep_q <= wdata_i[3:0];
			rt_left_q <= wdata_i[3:0];
			rt_len_q <= (new_len > len_limit) ? len_limit : new_len;
			if (wdata_i[RT_NEW])
				ab_q <= !ab_q;
		end else begin
			if (text_sent_i && (rt_left_q != 4'h0))
				rt_left_q <= rt_left_q - 4'h1;
			if (rt_len_q > len_limit)
				rt_len_q <= len_limit;
		end
	end

	// Character store; preset leaves contents but zeroes lengths/counts
	always_ff @(posedge sys_clk_i) begin
		if (hit(OFS_CHAR) && (wdata_i[CHAR_ADDR_LO +: 9] < 9'(CHR_DEPTH)))
			chr_mem[wdata_i[CHAR_ADDR_LO +: 9]] <= wdata_i[7:0];
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i)
			chr_addr_q <= 9'h0;
		else if (hit(OFS_CHAR))
			chr_addr_q <= wdata_i[CHAR_ADDR_LO +: 9];
	end

	// Rotating names
	assign rot_on = (rot_sec_q != 6'h0) && (rot_cnt_q != 5'h0);

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rot_sec_q <= 6'h0;
			rot_cnt_q <= 5'h0;
		end else if (wr_preset) begin
			rot_sec_q <= 6'h0;
			rot_cnt_q <= 5'h0;
		end else if (hit(OFS_ROTATE) && (wdata_i[5:0] <= ROT_SEC_MAX) &&
			(wdata_i[ROT_CNT_LO +: 5] <= ROT_NAMES)) begin
			rot_sec_q <= wdata_i[5:0];
			rot_cnt_q <= wdata_i[ROT_CNT_LO +: 5];
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rot_idx_q <= 5'h0;
			rot_elapsed_q <= 6'h0;
		end else if (!rot_on) begin
			rot_idx_q <= 5'h0;
			rot_elapsed_q <= 6'h0;
		end else if (sec_tick) begin
			if (rot_elapsed_q + 6'h1 >= rot_sec_q) begin
				rot_elapsed_q <= 6'h0;
				rot_idx_q <= (rot_idx_q + 5'h1 >= rot_cnt_q) ?
					5'h0 : rot_idx_q + 5'h1;
			end else begin
				rot_elapsed_q <= rot_elapsed_q + 6'h1;
			end
		end
	end

	assign name_base = rot_on ? (CHR_ROT + {1'b0, rot_idx_q, 3'h0}) : CHR_NAME;
	assign pair_addr = name_base + {6'h0, seg_idx_q, 1'b0};

	// Name segments: segment 0 goes twice when a charset is chosen
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			seg_idx_q <= 2'h0;
			cs_sent_q <= 1'b0;
			seg_valid_o <= 1'b0;
			seg_o <= '0;
		end else begin
			seg_valid_o <= seg_req_i;
			if (seg_req_i) begin
				if ((charset_q != 2'h0) && (seg_idx_q == 2'h0) && !cs_sent_q) begin
					seg_o <= '{is_charset: 1'b1, index: 2'h0,
						data: {14'h0, charset_q}};
					cs_sent_q <= 1'b1;
				end else begin
					seg_o <= '{is_charset: 1'b0, index: seg_idx_q,
						data: {chr_mem[pair_addr], chr_mem[pair_addr + 9'h1]}};
					seg_idx_q <= seg_idx_q + 2'h1;
					if (seg_idx_q == 2'h3)
						cs_sent_q <= 1'b0;
				end
			end
		end
	end

	// Settings driven toward the modulator
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			settings_o <= '0;
		end else begin
			settings_o.program_identifier <= pi_q;
			settings_o.genre_code <= genre_q;
			settings_o.genre_label_on <= g10a_q;
			settings_o.music_speech_flag <= music_q;
			settings_o.subcarrier_phase <= phase_q;
			settings_o.channel_arrangement <= chan_q;
			settings_o.input_source <= src_q;
			settings_o.text_ab <= ab_q;
			settings_o.text_len <= rt_len_q;
			settings_o.text_active <= (rt_left_q != 4'h0);
		end
	end

	// Read data appear the cycle after the strobe only
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rdata_o <= '0;
		end else if (!rd_i) begin
			rdata_o <= '0;
		end else begin
			unique case (addr_i)
				OFS_CTRL: rdata_o <= {21'h0, chan_q, 2'h0, src_q,
					g10a_q, bver_q, music_q, inject_on};
				OFS_MASK_CNT: rdata_o <= {16'h0, gap_cfg_q, cnt_cfg_q};
				OFS_MASK_A: rdata_o <= {6'h0, mask_q.blk[0]};
				OFS_MASK_B: rdata_o <= {6'h0, mask_q.blk[1]};
				OFS_MASK_C: rdata_o <= {6'h0, mask_q.blk[2]};
				OFS_MASK_D: rdata_o <= {6'h0, mask_q.blk[3]};
				OFS_PI: rdata_o <= {16'h0, pi_q};
				OFS_GENRE: rdata_o <= {22'h0, charset_q, 3'h0, genre_q};
				OFS_PHASE: rdata_o <= {23'h0, phase_q};
				OFS_RT_CFG: rdata_o <= {16'h0, ab_q, rt_len_q, rt_left_q, rt_rep_q};
				OFS_CHAR: rdata_o <= {7'h0, chr_addr_q, 8'h0, chr_mem[chr_addr_q]};
				OFS_ROTATE: rdata_o <= {11'h0, rot_idx_q, 3'h0, rot_cnt_q,
					2'h0, rot_sec_q};
				OFS_STATUS: rdata_o <= {14'h0, reject_q, ab_q, inject_left,
					6'h0, 1'b1, inject_on};
				default: rdata_o <= '0;
			endcase
		end
	end
endmodule // rcs_coder
`default_nettype wire

/* File: tb/rcs_coder_monitor.sv */
// Port checker for the coder settings block
`timescale 1ns/1ns
`default_nettype none
module rcs_coder_monitor
	import rcs_pkg::*;
(
	input wire logic                     sys_clk_i,
	input wire logic                     resetn_i,
	input wire logic [ADDR_W-1:0]        addr_i,
	input wire logic [DATA_W-1:0]        wdata_i,
	input wire logic                     wr_i,
	input wire logic                     rd_i,
	input wire logic [DATA_W-1:0]        rdata_o,
	input wire logic                     grp_valid_i,
	input wire logic                     grp_valid_o,
	input wire rcs_pkg::rcs_group_type    grp_o,
	input wire logic                     seg_req_i,
	input wire logic                     seg_valid_o,
	input wire rcs_pkg::rcs_segment_type  seg_o,
	input wire rcs_pkg::rcs_settings_type settings_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);

	grp_delay_a: assert property (grp_valid_o == $past(grp_valid_i))
		else $error("group valid not one cycle behind input");
	grp_hold_a: assert property (!$past(grp_valid_i) |-> $stable(grp_o))
		else $error("group output moved without a group");
	rd_idle_a: assert property (!$past(rd_i) |-> rdata_o == '0)
		else $error("read data outside its cycle");
	seg_pulse_a: assert property (seg_valid_o == $past(seg_req_i))
		else $error("segment valid not one cycle after request");
	charset_seg_a: assert property (seg_valid_o && seg_o.is_charset |->
		seg_o.index == 2'h0 && seg_o.data[15:2] == 14'h0)
		else $error("charset segment malformed");
	chan_legal_a: assert property (settings_o.channel_arrangement != 3'h0 |->
		settings_o.channel_arrangement inside {[CH_MIN:CH_MAX]} &&
		!(settings_o.channel_arrangement == CH_INDEP &&
		settings_o.input_source == SRC_TONE))
		else $error("illegal channel arrangement");
	phase_max_a: assert property (settings_o.subcarrier_phase <= PHASE_MAX)
		else $error("phase above limit");
	text_len_a: assert property (settings_o.text_len <= RT_LEN_A)
		else $error("text length above limit");
	music_wr_a: assert property (wr_i && addr_i == OFS_CTRL |-> ##2
		settings_o.music_speech_flag == $past(wdata_i[CTRL_MUSIC], 2))
		else $error("music flag not taken from write");
	pi_wr_a: assert property (wr_i && addr_i == OFS_PI |-> ##2
		settings_o.program_identifier == $past(wdata_i[15:0], 2))
		else $error("identifier not taken from write");
endmodule // rcs_coder_monitor

bind rcs_coder rcs_coder_monitor mon_u (.sys_clk_i, .resetn_i, .addr_i,
	.wdata_i, .wr_i, .rd_i, .rdata_o, .grp_valid_i, .grp_valid_o, .grp_o,
	.seg_req_i, .seg_valid_o, .seg_o, .settings_o);
`default_nettype wire

/* File: tb/rcs_host_model.sv */
// Remote controller model issuing register commands
`timescale 1ns/1ns
`default_nettype none
module rcs_host_model
	import rcs_pkg::*;
(
	input  wire logic              sys_clk_i,
	input  wire logic [DATA_W-1:0] rdata_i,
	output logic [ADDR_W-1:0]      addr_o,
	output logic [DATA_W-1:0]      wdata_o,
	output logic                   wr_o,
	output logic                   rd_o
);
	initial begin
		addr_o = '0;
		wdata_o = '0;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end

	// Fields always full width, zero padded
	task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge sys_clk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge sys_clk_i);
		wr_o <= 1'b0;
		// Released lines show garbage, not the old value
		addr_o <= ~a;
		wdata_o <= ~d;
	endtask

	task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		@(posedge sys_clk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge sys_clk_i);
		rd_o <= 1'b0;
		addr_o <= ~a;
		#1 d = rdata_i;
	endtask
endmodule // rcs_host_model
`default_nettype wire

/* File: tb/tb_rcs_coder.sv */
// Self-checking bench for the coder settings block
`timescale 1ns/1ns
`default_nettype none
module tb_rcs_coder;
	import rcs_pkg::*;
	localparam logic [31:0] CW = 32'h0000_0300;
	logic sys_clk_i = 1'b0, resetn_i = 1'b0, wr_i, rd_i;
	logic [ADDR_W-1:0] addr_i;
	logic [DATA_W-1:0] wdata_i, rdata_o, d;
	logic grp_valid_i = 1'b0, grp_valid_o, seg_req_i = 1'b0, seg_valid_o;
	logic text_sent_i = 1'b0;
	rcs_group_type grp_i = '0, grp_o, msk;
	rcs_segment_type seg_o;
	rcs_settings_type settings_o;
	int bad_count = 0, checked = 0;
	logic [25:0] n = 26'h0;

	always #20 sys_clk_i = ~sys_clk_i;
	rcs_coder #(.SEC_CYCLES(10)) dut_u (.sys_clk_i, .resetn_i, .addr_i, .wdata_i,
		.wr_i, .rd_i, .rdata_o, .grp_valid_i, .grp_i, .grp_valid_o, .grp_o,
		.seg_req_i, .seg_valid_o, .seg_o, .text_sent_i, .settings_o);
	rcs_host_model host_u (.sys_clk_i, .rdata_i(rdata_o), .addr_o(addr_i),
		.wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i));

	task automatic chk(input logic [104:0] got, exp, input string m);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] m, e);
		host_u.rd_reg(a, d);
		chk(d & m, e, "register read");
	endtask
	task automatic setm;
		for (int i = 0; i < 4; i++) host_u.wr_reg(OFS_MASK_A + 8'(i * 4), 32'(msk.blk[i]));
	endtask
	task automatic send(input logic err);
		rcs_group_type g;
		n = n + 26'h0123457;
		g = {4{n}};
		@(posedge sys_clk_i);
		grp_valid_i <= 1'b1;
		grp_i <= g;
		@(posedge sys_clk_i);
		grp_valid_i <= 1'b0;
		grp_i <= ~g;
		#1 chk({grp_valid_o, grp_o}, {1'b1, err ? g ^ msk : g}, "group out");
	endtask
	task automatic seg(output rcs_segment_type s);
		@(posedge sys_clk_i);
		seg_req_i <= 1'b1;
		@(posedge sys_clk_i);
		seg_req_i <= 1'b0;
		#1 s = seg_o;
		chk(seg_valid_o, 1'b1, "segment valid");
	endtask

	task automatic t_counted;
		msk = '0;
		msk.blk[0] = 26'h1;
		setm();
		host_u.wr_reg(OFS_MASK_CNT, 32'h0103);
		for (int r = 0; r < 2; r++) begin
			host_u.wr_reg(OFS_CTRL, CW | 32'h1);
			for (int k = 0; k < 7; k++) begin
				send(k < 5 && k % 2 == 0);
				if (k == 0) rchk(OFS_STATUS, 32'hFF01, 32'h0201);
			end
			rchk(OFS_STATUS, 32'h1, 32'h0);
		end
	endtask
	task automatic t_cont;
		msk.blk = {26'h3FFFFFF, 26'h2000000, 26'h0000155, 26'h0000001};
		setm();
		host_u.wr_reg(OFS_MASK_CNT, 32'h0);
		host_u.wr_reg(OFS_CTRL, CW | 32'h1);
		repeat (3) send(1'b1);
		rchk(OFS_STATUS, 32'h1, 32'h1);
		host_u.wr_reg(OFS_CTRL, CW);
		send(1'b0);
		rchk(OFS_STATUS, 32'h1, 32'h0);
	endtask
	task automatic t_chan;
		for (int c = 1; c <= 5; c++) begin
			host_u.wr_reg(OFS_CTRL, 32'(c) << 8);
			rchk(OFS_CTRL, 32'h700, 32'(c) << 8);
		end
		host_u.wr_reg(OFS_CTRL, CW);
		host_u.wr_reg(OFS_CTRL, 32'h532);
		rchk(OFS_CTRL, 32'h732, 32'h332);
		chk(settings_o.channel_arrangement, 3'h3, "chan out");
		rchk(OFS_STATUS, 32'h20000, 32'h20000);
		host_u.wr_reg(OFS_CTRL, CW);
	endtask
	task automatic t_misc;
		host_u.wr_reg(OFS_PHASE, 32'd359);
		host_u.wr_reg(OFS_PHASE, 32'd360);
		rchk(OFS_PHASE, 32'h1FF, 32'd359);
		chk(settings_o.subcarrier_phase, 9'd359, "phase out");
		host_u.wr_reg(OFS_PI, 32'hBEEF);
		rchk(OFS_PI, 32'hFFFF, 32'hBEEF);
		host_u.wr_reg(OFS_PRESET, 32'h1);
		rchk(OFS_PI, 32'hFFFF, 32'(PI_RST));
		rchk(8'h3C, 32'hFFFFFFFF, 32'h0);
	endtask
	task automatic t_seg;
		rcs_segment_type s;
		int hits;
		hits = 0;
		for (int i = 0; i < 8; i++) host_u.wr_reg(OFS_CHAR, (i << 16) | (32'h41 + i));
		repeat (4) begin
			seg(s);
			chk(s.is_charset, 1'b0, "no charset");
		end
		host_u.wr_reg(OFS_GENRE, 32'h200);
		for (int k = 0; k < 6; k++) begin
			seg(s);
			if (hits == 1)
				chk({s.index, s.data}, {2'h0, 16'h4142}, "pair");
			if (hits > 0) hits++;
			if (s.is_charset && k < 5) hits = 1;
			if (s.is_charset) chk(s.data, 16'h0002, "charset");
		end
		chk(hits > 0, 1'b1, "charset sent");
	endtask
	task automatic t_text;
		host_u.wr_reg(OFS_RT_CFG, 32'h8000 | (32'd70 << 8) | 32'h2);
		rchk(OFS_RT_CFG, 32'hFFFF, 32'hC022);
		for (int k = 0; k < 2; k++) begin
			@(posedge sys_clk_i);
			text_sent_i <= 1'b1;
			@(posedge sys_clk_i);
			text_sent_i <= 1'b0;
			repeat (2) @(posedge sys_clk_i);
			chk(settings_o.text_active, k == 0, "repeats left");
		end
		host_u.wr_reg(OFS_CTRL, CW | 32'hC);
		host_u.wr_reg(OFS_RT_CFG, 32'd70 << 8);
		rchk(OFS_RT_CFG, 32'h7F00, 32'h2000);
		chk(settings_o.genre_label_on, 1'b1, "label enable");
	endtask
	task automatic t_rot;
		rcs_segment_type s;
		int polls;
		polls = 0;
		host_u.wr_reg(OFS_CHAR, 32'h0018_0061);
		host_u.wr_reg(OFS_CHAR, 32'h0019_0062);
		host_u.wr_reg(OFS_ROTATE, 32'h0201);
		rchk(OFS_ROTATE, 32'h1F1F3F, 32'h0201);
		d = '0;
		// Bounded poll: the first tick lands within a dozen cycles
		while (d[20:16] != 5'h1 && polls < 20) begin
			host_u.rd_reg(OFS_ROTATE, d);
			polls++;
		end
		chk(d[20:16], 5'h1, "rotation advanced");
		seg(s);
		chk({s.is_charset, s.index, s.data}, {3'h0, 16'h6162}, "rot name");
		host_u.wr_reg(OFS_ROTATE, 32'h0);
		seg(s);
		chk({s.index, s.data}, {2'h1, 16'h4344}, "standard name");
	endtask

	task automatic stop_test;
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge sys_clk_i);
		bad_count++;
		stop_test();
	end
	initial begin
		repeat (16) @(posedge sys_clk_i);
		resetn_i <= 1'b1;
		t_counted();
		t_cont();
		t_chan();
		t_misc();
		t_seg();
		t_text();
		t_rot();
		stop_test();
	end
endmodule // tb_rcs_coder
`default_nettype wire
